// ---- verilog/sic_pkg.sv ----
// Package of register offsets, field positions and reset values for the system interrupt collector.
package sic_pkg;

  // ==========================================================================
  // Register port geometry.
  localparam int unsigned SIC_ADDR_W    = 8;
  localparam int unsigned SIC_DATA_W    = 16;
  localparam int unsigned SIC_PIN_COUNT = 4;
  localparam int unsigned SIC_FN_W      = 4;

  // ==========================================================================
  // Register offsets.
  localparam logic [7:0] SIC_OFF_INT_STATUS  = 8'h10;
  localparam logic [7:0] SIC_OFF_LIVE_STATUS = 8'h11;
  localparam logic [7:0] SIC_OFF_GLOBAL_MASK = 8'h12;
  localparam logic [7:0] SIC_OFF_INT_MASK    = 8'h13;

  // ==========================================================================
  // Field positions shared by the status and mask registers.
  localparam int unsigned SIC_BIT_THERMAL = 15;
  localparam int unsigned SIC_BIT_PIN1    = 11;
  localparam int unsigned SIC_BIT_TOUCH   = 10;
  localparam int unsigned SIC_BIT_PEN     = 9;
  localparam int unsigned SIC_BIT_AUX     = 8;
  localparam int unsigned SIC_BIT_UV      = 0;
  localparam int unsigned SIC_BIT_GLOBAL  = 0;
  localparam int unsigned SIC_BIT_LIVE_OT = 15;
  localparam int unsigned SIC_BIT_LIVE_UV = 0;

  // Status bits that exist; all others read as zero.
  localparam logic [15:0] SIC_STATUS_USED = 16'hFF01;
  localparam logic [15:0] SIC_GLOBAL_USED = 16'h0001;

  // ==========================================================================
  // Reset values.
  localparam logic [15:0] SIC_RST_INT_MASK    = 16'h0000;
  localparam logic        SIC_RST_GLOBAL_MASK = 1'b1;
  localparam logic [15:0] SIC_RST_RDATA       = 16'h0000;

  // Pin function code that routes the combined request onto a pin.
  localparam logic [3:0]  SIC_FN_IRQ_OUT      = 4'h3;

endpackage : sic_pkg

// ---- verilog/sic_edge_detect.sv ----
// Two-stage synchroniser with rising or both-edge event detection.
`timescale 1ns/1ps
module sic_edge_detect
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  input  wire logic both_edges,
  output logic      level_sync,
  output logic      edge_event
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  wire rise_w = sync_q & ~prev_q;
  wire fall_w = ~sync_q & prev_q;

  assign level_sync = sync_q;
  assign edge_event = rise_w | (both_edges & fall_w);

  a_rise_event : assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(sync_q) |-> edge_event)
    else $error("Rising edge of the synchronised input raised no event.");

  a_fall_mode : assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(sync_q) |-> (edge_event == both_edges))
    else $error("Falling edge event did not follow the edge mode.");

endmodule : sic_edge_detect

// ---- verilog/sic_sticky_flag.sv ----
// One sticky status flag: set by an event, cleared by a read, set wins.
`timescale 1ns/1ps
module sic_sticky_flag
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  output logic      flag_q
);

  logic flag_d;

  assign flag_d = set_pulse | (flag_q & ~clear_pulse);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

endmodule : sic_sticky_flag

// ---- verilog/sic_interrupt_collector.sv ----
// System interrupt collector: sticky status, masks, live flags and combined request.
`timescale 1ns/1ps
module sic_interrupt_collector
  import sic_pkg::*;
(
  input  wire logic                                      core_clk,
  input  wire logic                                      reset_n,
  // Register port from the control interface.
  input  wire logic                                      reg_wr_en,
  input  wire logic                                      reg_rd_en,
  input  wire logic [sic_pkg::SIC_ADDR_W-1:0]            reg_addr,
  input  wire logic [sic_pkg::SIC_DATA_W-1:0]            reg_wdata,
  output logic      [sic_pkg::SIC_DATA_W-1:0]            reg_rdata,
  // Interrupt sources.
  input  wire logic                                      overtemp_live,
  input  wire logic                                      undervoltage_live,
  input  wire logic [sic_pkg::SIC_PIN_COUNT-1:0]         pin_level,
  input  wire logic                                      touch_result_event,
  input  wire logic                                      pen_down_event,
  input  wire logic                                      aux_conv_event,
  // Pin configuration held by the pin control logic.
  input  wire logic [sic_pkg::SIC_PIN_COUNT-1:0]         pin_edge_mode,
  input  wire logic [sic_pkg::SIC_PIN_COUNT*sic_pkg::SIC_FN_W-1:0] pin_function_select,
  // Combined request and its routing onto pins.
  output logic                                           irq_out,
  output logic      [sic_pkg::SIC_PIN_COUNT-1:0]         pin_irq_level,
  output logic      [sic_pkg::SIC_PIN_COUNT-1:0]         pin_irq_oe
);

  import sic_pkg::*;

  // ==========================================================================
  // Source conditioning.
  logic [SIC_PIN_COUNT-1:0] pin_sync;
  logic [SIC_PIN_COUNT-1:0] pin_event;
  logic                     overtemp_sync;
  logic                     undervoltage_sync;
  logic                     thermal_rise;
  logic                     undervoltage_rise;

  genvar gi;
  generate
    for (gi = 0; gi < SIC_PIN_COUNT; gi++)
    begin : g_pin
      sic_edge_detect u_pin_edge
      (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .async_in   (pin_level[gi]),
        .both_edges (pin_edge_mode[gi]),
        .level_sync (pin_sync[gi]),
        .edge_event (pin_event[gi])
      );
    end
  endgenerate

  // Thermal and undervoltage interrupts fire when the condition starts.
  sic_edge_detect u_overtemp_edge
  (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .async_in   (overtemp_live),
    .both_edges (1'b0),
    .level_sync (overtemp_sync),
    .edge_event (thermal_rise)
  );

  sic_edge_detect u_undervoltage_edge
  (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .async_in   (undervoltage_live),
    .both_edges (1'b0),
    .level_sync (undervoltage_sync),
    .edge_event (undervoltage_rise)
  );

  // ==========================================================================
  // Register decode.
  wire sel_status = (reg_addr == SIC_OFF_INT_STATUS);
  wire sel_live   = (reg_addr == SIC_OFF_LIVE_STATUS);
  wire sel_global = (reg_addr == SIC_OFF_GLOBAL_MASK);
  wire sel_mask   = (reg_addr == SIC_OFF_INT_MASK);

  wire rd_status  = reg_rd_en & sel_status;
  wire wr_global  = reg_wr_en & sel_global;
  wire wr_mask    = reg_wr_en & sel_mask;

  // ==========================================================================
  // Sticky status register.
  logic [15:0] set_vec;
  logic [15:0] status_q;

  assign set_vec[SIC_BIT_THERMAL]                           = thermal_rise;
  assign set_vec[SIC_BIT_PIN1+SIC_PIN_COUNT-1:SIC_BIT_PIN1] = pin_event;
  assign set_vec[SIC_BIT_TOUCH]                             = touch_result_event;
  assign set_vec[SIC_BIT_PEN]                               = pen_down_event;
  assign set_vec[SIC_BIT_AUX]                               = aux_conv_event;
  assign set_vec[SIC_BIT_AUX-1:SIC_BIT_UV+1]                = '0;
  assign set_vec[SIC_BIT_UV]                                = undervoltage_rise;

  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_status
      if (SIC_STATUS_USED[gi])
      begin : g_used
        sic_sticky_flag u_flag
        (
          .core_clk    (core_clk),
          .reset_n     (reset_n),
          .set_pulse   (set_vec[gi]),
          .clear_pulse (rd_status),
          .flag_q      (status_q[gi])
        );
      end
      else
      begin : g_unused
        assign status_q[gi] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================================
  // Mask registers.
  logic [15:0] int_mask_q;
  logic        global_mask_q;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      int_mask_q    <= SIC_RST_INT_MASK;
      global_mask_q <= SIC_RST_GLOBAL_MASK;
    end
    else
    begin
      if (wr_mask)
        int_mask_q <= reg_wdata & SIC_STATUS_USED;
      if (wr_global)
        global_mask_q <= reg_wdata[SIC_BIT_GLOBAL];
    end
  end

  // ==========================================================================
  // Live flags and read data.
  logic [15:0] live_vec;

  assign live_vec[SIC_BIT_LIVE_OT]                   = overtemp_sync;
  assign live_vec[SIC_BIT_LIVE_OT-1:SIC_BIT_LIVE_UV+1] = '0;
  assign live_vec[SIC_BIT_LIVE_UV]                   = undervoltage_sync;

  logic [15:0] rdata_mux;

  assign rdata_mux = sel_status ? status_q :
                     sel_live   ? live_vec :
                     sel_global ? {15'h0000, global_mask_q} :
                     sel_mask   ? int_mask_q : 16'h0000;

  // The status value is captured in the same edge that clears it.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= SIC_RST_RDATA;
    else if (reg_rd_en)
      reg_rdata <= rdata_mux;
  end

  // ==========================================================================
  // Combined request and pin routing.
  logic [15:0]              pending_vec;
  logic                     irq_d;
  logic [SIC_PIN_COUNT-1:0] pin_route;

  assign pending_vec = status_q & ~int_mask_q;
  assign irq_d       = (|pending_vec) & ~global_mask_q;

  generate
    for (gi = 0; gi < SIC_PIN_COUNT; gi++)
    begin : g_route
      assign pin_route[gi] = (pin_function_select[gi*SIC_FN_W +: SIC_FN_W] == SIC_FN_IRQ_OUT);
    end
  endgenerate

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_out       <= 1'b0;
      pin_irq_level <= '0;
      pin_irq_oe    <= '0;
    end
    else
    begin
      irq_out       <= irq_d;
      pin_irq_level <= pin_route & {SIC_PIN_COUNT{irq_d}};
      pin_irq_oe    <= pin_route;
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_status_read;
    reg_rd_en && (reg_addr == SIC_OFF_INT_STATUS);
  endsequence

  sequence s_no_status_read;
    !(reg_rd_en && (reg_addr == SIC_OFF_INT_STATUS));
  endsequence

  a_status_holds : assert property (s_no_status_read |=>
    ((status_q & $past(status_q)) == $past(status_q)))
    else $error("Latched status bit dropped without a status read.");

  a_read_clears : assert property (s_status_read ##0 (set_vec == 16'h0000) |=>
    (status_q == 16'h0000) && (reg_rdata == $past(status_q)))
    else $error("Status read did not return and clear the latched bits.");

  a_set_wins_read : assert property (s_status_read ##0 (set_vec != 16'h0000) |=>
    (status_q == ($past(set_vec) & SIC_STATUS_USED)))
    else $error("Event coinciding with a status read was lost.");

  a_thermal_bit : assert property ($rose(overtemp_sync) |-> ##1 status_q[15])
    else $error("Thermal onset did not set status bit 15.");

  a_pin_bits : assert property ((pin_event != '0) |=>
    ((status_q[14:11] & $past(pin_event)) == $past(pin_event)))
    else $error("Pin event did not set its status bit.");

  a_touch_pen_aux : assert property ((touch_result_event || pen_down_event || aux_conv_event) |=>
    (status_q[10:8] & {$past(touch_result_event), $past(pen_down_event), $past(aux_conv_event)})
    == {$past(touch_result_event), $past(pen_down_event), $past(aux_conv_event)})
    else $error("Touch, pen or auxiliary event not latched.");

  a_uv_bit : assert property ($rose(undervoltage_sync) |-> ##1 status_q[0])
    else $error("Undervoltage onset did not set status bit 0.");

  a_live_read : assert property ((reg_rd_en && reg_addr == SIC_OFF_LIVE_STATUS) |=>
    reg_rdata == {$past(overtemp_sync), 14'h0000, $past(undervoltage_sync)})
    else $error("Live flag register read wrong value.");

  a_global_blocks : assert property (global_mask_q |=> !irq_out)
    else $error("Request asserted while globally masked.");

  a_irq_follows : assert property ((!global_mask_q && (pending_vec != 16'h0000)) |=> irq_out)
    else $error("Unmasked pending interrupt did not raise the request.");

  a_mask_excludes : assert property (((status_q & ~int_mask_q) == 16'h0000) |=> !irq_out)
    else $error("Request raised with every latched source masked.");

  a_pin_route : assert property ((pin_route != '0) |=>
    (pin_irq_oe == $past(pin_route)) && (pin_irq_level == ($past(pin_route) & {SIC_PIN_COUNT{irq_out}})))
    else $error("Request not driven onto the selected pin.");

  sequence s_mask_write;
    reg_wr_en && (reg_addr == SIC_OFF_INT_MASK);
  endsequence

  sequence s_global_write;
    reg_wr_en && (reg_addr == SIC_OFF_GLOBAL_MASK);
  endsequence

  a_mask_write : assert property (s_mask_write |=>
    (int_mask_q == ($past(reg_wdata) & SIC_STATUS_USED)))
    else $error("Mask write did not store the implemented bits.");

  a_global_write : assert property (s_global_write |=>
    (global_mask_q == $past(reg_wdata[SIC_BIT_GLOBAL])))
    else $error("Global mask write did not take effect.");

  a_no_spurious : assert property (s_no_status_read ##0 (set_vec == 16'h0000) |=>
    (status_q == $past(status_q)))
    else $error("Status changed with no event and no status read.");

  a_pin_released : assert property ((pin_route == '0) |=>
    (pin_irq_oe == '0) && (pin_irq_level == '0))
    else $error("Request driven onto a pin not selected for it.");

  // Read data is a holding register, so a host may sample it late.
  a_rdata_stands : assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("Read data changed without a read strobe.");

endmodule : sic_interrupt_collector

// ---- tb/sic_host_model.sv ----
// Host processor model that watches the interrupt pins of the collector.
`timescale 1ns/1ps
module sic_host_model
(
  input  wire logic [3:0] pin_irq_level,
  input  wire logic [3:0] pin_irq_oe,
  output logic            irq_line
);
  // ==========================================================================
  // Pin wires
  // Undriven pins are taken as pulled low, so a released pin never shows a stale high.
  logic [3:0] pin_wire;

  assign pin_wire = pin_irq_oe & pin_irq_level;
  assign irq_line = |pin_wire;
endmodule : sic_host_model

// ---- tb/tb_system_interrupt_collector.sv ----
// Self-checking testbench of the system interrupt collector.
`timescale 1ns/1ps
module tb_system_interrupt_collector;
  import sic_pkg::*;

  // ==========================================================================
  // Signals
  logic        core_clk, reset_n, reg_wr_en, reg_rd_en;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pin_function_select;
  logic        ot, uv, touch, pen, aux, irq_out, irq_line;
  logic [3:0]  pin_level, pin_edge_mode, pin_irq_level, pin_irq_oe;
  int          err_count, tests_run;
  int          bits[9] = '{15, 14, 13, 12, 11, 10, 9, 8, 0};

  sic_interrupt_collector DUT (
    .core_clk(core_clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .overtemp_live(ot), .undervoltage_live(uv), .pin_level(pin_level),
    .touch_result_event(touch), .pen_down_event(pen), .aux_conv_event(aux),
    .pin_edge_mode(pin_edge_mode), .pin_function_select(pin_function_select),
    .irq_out(irq_out), .pin_irq_level(pin_irq_level), .pin_irq_oe(pin_irq_oe));

  sic_host_model host (.pin_irq_level(pin_irq_level), .pin_irq_oe(pin_irq_oe), .irq_line(irq_line));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    step(1);
    reg_wr_en = 1'b0;
    step(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    step(1);
    reg_rd_en = 1'b0;
    check($sformatf("reg %h", a), reg_rdata, exp);
    step(1);
  endtask : rd

  // Raises the source of one status bit, holds it, then drops it again.
  task automatic fire(input int b);
    case (b)
      0:       uv = 1'b1;
      8:       aux = 1'b1;
      9:       pen = 1'b1;
      10:      touch = 1'b1;
      15:      ot = 1'b1;
      default: pin_level[b-11] = 1'b1;
    endcase
    step(5);
    {ot, uv, touch, pen, aux} = 5'h00;
    pin_level = 4'h0;
    step(5);
  endtask : fire

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // ==========================================================================
  // Test sequence
  initial
  begin
    {reset_n, reg_wr_en, reg_rd_en, ot, uv, touch, pen, aux} = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    pin_level = 4'h0;
    pin_edge_mode = 4'h0;
    pin_function_select = 16'h0000;
    repeat (3) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    step(3);
    rd(SIC_OFF_GLOBAL_MASK, 16'h0001);
    rd(SIC_OFF_INT_MASK, 16'h0000);
    rd(SIC_OFF_INT_STATUS, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(SIC_OFF_LIVE_STATUS, 16'hFFFF);
    rd(SIC_OFF_LIVE_STATUS, 16'h0000);
    wr(SIC_OFF_INT_MASK, 16'hFFFF);
    rd(SIC_OFF_INT_MASK, 16'hFF01);
    wr(SIC_OFF_INT_MASK, 16'h0000);
    $display("test registers done");
    fire(8);
    check("irq_out", {15'h0, irq_out}, 16'h0000);
    wr(SIC_OFF_GLOBAL_MASK, 16'h0000);
    step(1);
    check("irq_out", {15'h0, irq_out}, 16'h0001);
    rd(SIC_OFF_INT_STATUS, 16'h0100);
    $display("test global mask done");
    pin_function_select = 16'h0030;
    step(2);
    check("pin_irq_oe", {12'h0, pin_irq_oe}, 16'h0002);
    foreach (bits[i])
    begin
      fire(bits[i]);
      check("irq_out", {15'h0, irq_out}, 16'h0001);
      check("host irq", {15'h0, irq_line}, 16'h0001);
      rd(SIC_OFF_INT_STATUS, 16'h0001 << bits[i]);
      rd(SIC_OFF_INT_STATUS, 16'h0000);
      check("irq_out", {15'h0, irq_out}, 16'h0000);
      check("host irq", {15'h0, irq_line}, 16'h0000);
      wr(SIC_OFF_INT_MASK, 16'h0001 << bits[i]);
      fire(bits[i]);
      check("irq_out", {15'h0, irq_out}, 16'h0000);
      check("host irq", {15'h0, irq_line}, 16'h0000);
      rd(SIC_OFF_INT_STATUS, 16'h0001 << bits[i]);
      wr(SIC_OFF_INT_MASK, 16'h0000);
    end
    pin_function_select = 16'h0020;
    step(2);
    check("pin_irq_oe", {12'h0, pin_irq_oe}, 16'h0000);
    fire(9);
    wr(SIC_OFF_GLOBAL_MASK, 16'h0001);
    step(1);
    check("irq_out", {15'h0, irq_out}, 16'h0000);
    rd(SIC_OFF_GLOBAL_MASK, 16'h0001);
    wr(SIC_OFF_GLOBAL_MASK, 16'h0000);
    step(1);
    check("irq_out", {15'h0, irq_out}, 16'h0001);
    check("host irq", {15'h0, irq_line}, 16'h0000);
    rd(SIC_OFF_INT_STATUS, 16'h0200);
    $display("test sources and masks done");
    {ot, uv} = 2'b11;
    step(5);
    rd(SIC_OFF_LIVE_STATUS, 16'h8001);
    {ot, uv} = 2'b00;
    step(5);
    rd(SIC_OFF_LIVE_STATUS, 16'h0000);
    rd(SIC_OFF_INT_STATUS, 16'h8001);
    for (int m = 0; m < 2; m++)
    begin
      pin_edge_mode[0] = m[0];
      pin_level[0] = 1'b1;
      step(5);
      rd(SIC_OFF_INT_STATUS, 16'h0800);
      pin_level[0] = 1'b0;
      step(5);
      rd(SIC_OFF_INT_STATUS, m ? 16'h0800 : 16'h0000);
    end
    $display("test live and edge mode done");
    reg_rd_en = 1'b1;
    reg_addr = SIC_OFF_INT_STATUS;
    aux = 1'b1;
    step(1);
    {reg_rd_en, aux} = 2'b00;
    check("reg 10 during event", reg_rdata, 16'h0000);
    step(1);
    rd(SIC_OFF_INT_STATUS, 16'h0100);
    $display("test read collision done");
    complete_run();
  end

  initial
  begin
    #300us;
    err_count++;
    complete_run();
  end
endmodule : tb_system_interrupt_collector
